/* rtl/bst_tap.sv */
`timescale 1ns/1ps
`default_nettype none
`include "bst_defines.svh"
module bst_tap
  import bst_pkg::*;
#(
  parameter int VARIANT = 0,
  parameter bit HAS_IDCODE = 1'b1,
  parameter bit HAS_SIG = 1'b1,
  parameter logic [3:0] ID_VERSION = 4'h1,   // arbitrary value
  parameter logic [15:0] ID_PART = 16'h5a3c, // arbitrary value
  parameter logic [10:0] ID_MFR = 11'h2a5,   // arbitrary value
  localparam int BSR_LEN = (VARIANT == 0) ? `BST_BSR_LEN_0 : (VARIANT == 1) ? `BST_BSR_LEN_1 :
                           (VARIANT == 2) ? `BST_BSR_LEN_2 : `BST_BSR_LEN_3,
  localparam int NPIN = BSR_LEN / `BST_CELLS_PER_PIN
)
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic tck,
  input wire bst_jtag_in_type jtag_in,
  output bst_tdo_type tdo_pad,
  input wire logic tap_en,
  input wire logic user_tdo_out,
  input wire logic user_tdo_oe,
  input wire logic [NPIN-1:0] pad_in,
  input wire logic [NPIN-1:0] core_out,
  input wire logic [NPIN-1:0] core_oe,
  output logic [NPIN-1:0] pad_out,
  output logic [NPIN-1:0] pad_oe,
  output logic isp_active
);

  localparam logic [9:0] IR_RST = HAS_IDCODE ? `BST_OP_IDCODE : `BST_OP_BYPASS;

  bst_tap_state_type state_reg, state_next;
  bst_dr_sel_type dr_sel;
  logic en_meta_reg, en_reg;
  logic [NPIN-1:0] pin_meta_reg, pin_sync_reg, cout_meta_reg, cout_sync_reg;
  logic [NPIN-1:0] coe_meta_reg, coe_sync_reg;
  logic [9:0] ir_shift_reg, ir_reg;
  logic [BSR_LEN-1:0] bsr_shift_reg, bsr_upd_reg;
  logic byp_reg;
  logic [31:0] id_shift_reg;
  logic [15:0] sig_shift_reg, data_shift_reg;
  logic [7:0] addr_shift_reg, addr_reg;
  logic [15:0] nv_mem [0:`BST_NV_DEPTH-1];
  logic isp_mode_reg, ext_mode_reg, upd_tgl_reg, tdo_reg, tdo_oe_reg, dr_out;

  // static strap, but crosses into the test clock before use
  always_ff @(posedge tck or negedge rst_n)
    if (!rst_n)
    begin
      en_meta_reg <= 1'b0;
      en_reg <= 1'b0;
    end
    else
    begin
      en_meta_reg <= tap_en;
      en_reg <= en_meta_reg;
    end

  always_ff @(posedge tck or negedge rst_n)
    if (!rst_n)
    begin
      pin_meta_reg <= '0;
      pin_sync_reg <= '0;
      cout_meta_reg <= '0;
      cout_sync_reg <= '0;
      coe_meta_reg <= '0;
      coe_sync_reg <= '0;
    end
    else
    begin
      pin_meta_reg <= pad_in;
      pin_sync_reg <= pin_meta_reg;
      cout_meta_reg <= core_out;
      cout_sync_reg <= cout_meta_reg;
      coe_meta_reg <= core_oe;
      coe_sync_reg <= coe_meta_reg;
    end

  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      ST_TLR: state_next = jtag_in.tms ? ST_TLR : ST_RTI;
      ST_RTI: state_next = jtag_in.tms ? ST_SEL_DR : ST_RTI;
      ST_SEL_DR: state_next = jtag_in.tms ? ST_SEL_IR : ST_CAP_DR;
      ST_CAP_DR: state_next = jtag_in.tms ? ST_EX1_DR : ST_SH_DR;
      ST_SH_DR: state_next = jtag_in.tms ? ST_EX1_DR : ST_SH_DR;
      ST_EX1_DR: state_next = jtag_in.tms ? ST_UPD_DR : ST_PAU_DR;
      ST_PAU_DR: state_next = jtag_in.tms ? ST_EX2_DR : ST_PAU_DR;
      ST_EX2_DR: state_next = jtag_in.tms ? ST_UPD_DR : ST_SH_DR;
      ST_UPD_DR: state_next = jtag_in.tms ? ST_SEL_DR : ST_RTI;
      ST_SEL_IR: state_next = jtag_in.tms ? ST_TLR : ST_CAP_IR;
      ST_CAP_IR: state_next = jtag_in.tms ? ST_EX1_IR : ST_SH_IR;
      ST_SH_IR: state_next = jtag_in.tms ? ST_EX1_IR : ST_SH_IR;
      ST_EX1_IR: state_next = jtag_in.tms ? ST_UPD_IR : ST_PAU_IR;
      ST_PAU_IR: state_next = jtag_in.tms ? ST_EX2_IR : ST_PAU_IR;
      ST_EX2_IR: state_next = jtag_in.tms ? ST_UPD_IR : ST_SH_IR;
      ST_UPD_IR: state_next = jtag_in.tms ? ST_SEL_DR : ST_RTI;
      default: state_next = ST_TLR;
    endcase
  end

  // disabled port parks the controller in reset
  always_ff @(posedge tck or negedge rst_n)
    if (!rst_n)
      state_reg <= ST_TLR;
    else if (!en_reg)
      state_reg <= ST_TLR;
    else
      state_reg <= state_next;

  always_ff @(posedge tck or negedge rst_n)
    if (!rst_n)
    begin
      ir_shift_reg <= '0;
      ir_reg <= IR_RST;
    end
    else if (state_reg == ST_TLR)
      ir_reg <= IR_RST;
    else if (state_reg == ST_CAP_IR)
      ir_shift_reg <= `BST_IR_CAPTURE;
    else if (state_reg == ST_SH_IR)
      ir_shift_reg <= {jtag_in.tdi, ir_shift_reg[9:1]};
    else if (state_reg == ST_UPD_IR)
      ir_reg <= ir_shift_reg;

  always_comb
  begin
    case (ir_reg)
      `BST_OP_EXTEST, `BST_OP_SAMPLE: dr_sel = SEL_BSR;
      `BST_OP_IDCODE: dr_sel = HAS_IDCODE ? SEL_ID : SEL_BYP;
      `BST_OP_USERSIG: dr_sel = HAS_SIG ? SEL_SIG : SEL_BYP;
      `BST_OP_ISP_ADDR: dr_sel = SEL_ADDR;
      `BST_OP_ISP_PROGRAM, `BST_OP_ISP_READ: dr_sel = SEL_DATA;
      default: dr_sel = SEL_BYP;
    endcase
  end

  always_comb
  begin
    case (dr_sel)
      SEL_BSR: dr_out = bsr_shift_reg[0];
      SEL_ID: dr_out = id_shift_reg[0];
      SEL_SIG: dr_out = sig_shift_reg[0];
      SEL_ADDR: dr_out = addr_shift_reg[0];
      SEL_DATA: dr_out = data_shift_reg[0];
      default: dr_out = byp_reg;
    endcase
  end

  always_ff @(posedge tck or negedge rst_n)
    if (!rst_n)
      byp_reg <= 1'b0;
    else if (state_reg == ST_CAP_DR && dr_sel == SEL_BYP)
      byp_reg <= 1'b0;
    else if (state_reg == ST_SH_DR && dr_sel == SEL_BYP)
      byp_reg <= jtag_in.tdi;

  // capture works in any mode, so sampling never disturbs the core
  always_ff @(posedge tck or negedge rst_n)
    if (!rst_n)
      bsr_shift_reg <= '0;
    else if (state_reg == ST_CAP_DR && dr_sel == SEL_BSR)
    begin
      for (int i = 0; i < NPIN; i++)
      begin
        bsr_shift_reg[3*i + `BST_CELL_IN] <= pin_sync_reg[i];
        bsr_shift_reg[3*i + `BST_CELL_OUT] <= cout_sync_reg[i];
        bsr_shift_reg[3*i + `BST_CELL_OE] <= coe_sync_reg[i];
      end
    end
    else if (state_reg == ST_SH_DR && dr_sel == SEL_BSR)
      bsr_shift_reg <= {jtag_in.tdi, bsr_shift_reg[BSR_LEN-1:1]};

  always_ff @(posedge tck or negedge rst_n)
    if (!rst_n)
      bsr_upd_reg <= '0;
    else if (state_reg == ST_UPD_DR && dr_sel == SEL_BSR)
      bsr_upd_reg <= bsr_shift_reg;

  always_ff @(posedge tck or negedge rst_n)
    if (!rst_n)
      id_shift_reg <= '0;
    else if (state_reg == ST_CAP_DR && dr_sel == SEL_ID)
      id_shift_reg <= {ID_VERSION, ID_PART, ID_MFR, `BST_ID_LSB};
    else if (state_reg == ST_SH_DR && dr_sel == SEL_ID)
      id_shift_reg <= {jtag_in.tdi, id_shift_reg[31:1]};

  always_ff @(posedge tck or negedge rst_n)
    if (!rst_n)
      sig_shift_reg <= '0;
    else if (state_reg == ST_CAP_DR && dr_sel == SEL_SIG)
      sig_shift_reg <= nv_mem[`BST_SIG_ADDR];
    else if (state_reg == ST_SH_DR && dr_sel == SEL_SIG)
      sig_shift_reg <= {jtag_in.tdi, sig_shift_reg[15:1]};

  always_ff @(posedge tck or negedge rst_n)
    if (!rst_n)
      isp_mode_reg <= 1'b0;
    else if (state_reg == ST_TLR || (state_reg == ST_UPD_IR && ir_shift_reg == `BST_OP_ISP_DISABLE))
      isp_mode_reg <= 1'b0;
    else if (state_reg == ST_UPD_IR && ir_shift_reg == `BST_OP_ISP_ENABLE)
      isp_mode_reg <= 1'b1;

  // one registered bit for the crossing, a decoded compare could glitch
  always_ff @(posedge tck or negedge rst_n)
    if (!rst_n)
      ext_mode_reg <= 1'b0;
    else if (state_reg == ST_TLR)
      ext_mode_reg <= 1'b0;
    else if (state_reg == ST_UPD_IR)
      ext_mode_reg <= (ir_shift_reg == `BST_OP_EXTEST);

  always_ff @(posedge tck or negedge rst_n)
    if (!rst_n)
    begin
      addr_shift_reg <= '0;
      addr_reg <= `BST_ADDR_RST;
    end
    else if (state_reg == ST_SH_DR && dr_sel == SEL_ADDR)
      addr_shift_reg <= {jtag_in.tdi, addr_shift_reg[7:1]};
    else if (state_reg == ST_UPD_DR && dr_sel == SEL_ADDR && isp_mode_reg)
      addr_reg <= addr_shift_reg;

  // readback lets the host verify each word after it is programmed
  always_ff @(posedge tck or negedge rst_n)
    if (!rst_n)
      data_shift_reg <= '0;
    else if (state_reg == ST_CAP_DR && dr_sel == SEL_DATA && ir_reg == `BST_OP_ISP_READ)
      data_shift_reg <= isp_mode_reg ? nv_mem[addr_reg] : '0;
    else if (state_reg == ST_SH_DR && dr_sel == SEL_DATA)
      data_shift_reg <= {jtag_in.tdi, data_shift_reg[15:1]};

  // nonvolatile contents survive reset, so no reset branch
  always_ff @(posedge tck)
    if (isp_mode_reg && state_reg == ST_UPD_IR && ir_shift_reg == `BST_OP_ISP_ERASE)
    begin
      for (int i = 0; i < `BST_NV_DEPTH; i++)
        nv_mem[i] <= `BST_NV_ERASED;
    end
    else if (isp_mode_reg && state_reg == ST_UPD_DR && ir_reg == `BST_OP_ISP_PROGRAM)
      nv_mem[addr_reg] <= data_shift_reg;

  always_ff @(negedge tck or negedge rst_n)
    if (!rst_n)
    begin
      tdo_reg <= 1'b0;
      tdo_oe_reg <= 1'b0;
    end
    else
    begin
      tdo_reg <= (state_reg == ST_SH_IR) ? ir_shift_reg[0] : dr_out;
      tdo_oe_reg <= (state_reg == ST_SH_IR) || (state_reg == ST_SH_DR);
    end

  // new pattern announced by toggle; host must leave a few ref cycles between updates
  always_ff @(posedge tck or negedge rst_n)
    if (!rst_n)
      upd_tgl_reg <= 1'b0;
    else if ((state_reg == ST_UPD_DR && dr_sel == SEL_BSR) || state_reg == ST_UPD_IR)
      upd_tgl_reg <= ~upd_tgl_reg;

  logic ext_meta_reg, ext_reg, isp_meta_reg, isp_reg, tgl_meta_reg, tgl_reg, tgl_old_reg;
  logic en_r_meta_reg, en_r_reg, utdo_reg, utdo_oe_reg;
  logic [NPIN-1:0] sh_out_reg, sh_oe_reg;

  always_ff @(posedge ref_clk or negedge rst_n)
    if (!rst_n)
    begin
      ext_meta_reg <= 1'b0;
      ext_reg <= 1'b0;
      isp_meta_reg <= 1'b0;
      isp_reg <= 1'b0;
      tgl_meta_reg <= 1'b0;
      tgl_reg <= 1'b0;
      tgl_old_reg <= 1'b0;
      en_r_meta_reg <= 1'b0;
      en_r_reg <= 1'b0;
    end
    else
    begin
      ext_meta_reg <= ext_mode_reg;
      ext_reg <= ext_meta_reg;
      isp_meta_reg <= isp_mode_reg;
      isp_reg <= isp_meta_reg;
      tgl_meta_reg <= upd_tgl_reg;
      tgl_reg <= tgl_meta_reg;
      tgl_old_reg <= tgl_reg;
      en_r_meta_reg <= tap_en;
      en_r_reg <= en_r_meta_reg;
    end

  always_ff @(posedge ref_clk or negedge rst_n)
    if (!rst_n)
    begin
      sh_out_reg <= '0;
      sh_oe_reg <= '0;
    end
    else if (tgl_reg != tgl_old_reg)
    begin
      for (int i = 0; i < NPIN; i++)
      begin
        sh_out_reg[i] <= bsr_upd_reg[3*i + `BST_CELL_OUT];
        sh_oe_reg[i] <= bsr_upd_reg[3*i + `BST_CELL_OE];
      end
    end

  always_ff @(posedge ref_clk or negedge rst_n)
    if (!rst_n)
    begin
      pad_out <= '0;
      pad_oe <= '0;
      isp_active <= 1'b0;
    end
    else
    begin
      isp_active <= isp_reg;
      pad_out <= ext_reg ? sh_out_reg : core_out;
      pad_oe <= isp_reg ? '0 : (ext_reg ? sh_oe_reg : core_oe);
    end

  always_ff @(posedge ref_clk or negedge rst_n)
    if (!rst_n)
    begin
      utdo_reg <= 1'b0;
      utdo_oe_reg <= 1'b0;
    end
    else
    begin
      utdo_reg <= user_tdo_out;
      utdo_oe_reg <= user_tdo_oe;
    end

  assign tdo_pad = en_r_reg ? bst_tdo_type'{tdo: tdo_reg, oe: tdo_oe_reg} :
                              bst_tdo_type'{tdo: utdo_reg, oe: utdo_oe_reg};

  property p_tlr;
    @(posedge tck) disable iff (!rst_n) jtag_in.tms [*5] |=> state_reg == ST_TLR;
  endproperty
  a_tlr: assert property (p_tlr) else $error("five tms highs did not reach reset");
  property p_ir_load;
    @(posedge tck) disable iff (!rst_n) state_reg == ST_UPD_IR && en_reg |=>
      ir_reg == $past(ir_shift_reg);
  endproperty
  a_ir_load: assert property (p_ir_load) else $error("instruction not loaded");
  property p_byp;
    @(posedge tck) disable iff (!rst_n) (state_reg == ST_SH_DR && dr_sel == SEL_BYP)
      ##1 state_reg == ST_SH_DR |-> tdo_reg == $past(jtag_in.tdi);
  endproperty
  a_byp: assert property (p_byp) else $error("bypass delay is not one bit");
  property p_id_word;
    @(posedge tck) disable iff (!rst_n) state_reg == ST_CAP_DR && dr_sel == SEL_ID |=>
      id_shift_reg == {ID_VERSION, ID_PART, ID_MFR, 1'b1};
  endproperty
  a_id_word: assert property (p_id_word) else $error("identity word wrong");
  property p_id_lsb;
    @(posedge tck) disable iff (!rst_n) state_reg == ST_CAP_DR && dr_sel == SEL_ID
      ##1 state_reg == ST_SH_DR |-> tdo_reg;
  endproperty
  a_id_lsb: assert property (p_id_lsb) else $error("identity lsb not one");
  property p_id_shift;
    @(posedge tck) disable iff (!rst_n) state_reg == ST_SH_DR && dr_sel == SEL_ID |=>
      id_shift_reg[30:0] == $past(id_shift_reg[31:1]);
  endproperty
  a_id_shift: assert property (p_id_shift) else $error("identity shift broken");
  property p_sig;
    @(posedge tck) disable iff (!rst_n) state_reg == ST_CAP_DR && dr_sel == SEL_SIG |=>
      sig_shift_reg == $past(nv_mem[`BST_SIG_ADDR]);
  endproperty
  a_sig: assert property (p_sig) else $error("signature not captured");
  property p_sample;
    @(posedge tck) disable iff (!rst_n) state_reg == ST_CAP_DR && dr_sel == SEL_BSR |=>
      bsr_shift_reg[`BST_CELL_IN] == $past(pin_sync_reg[0]);
  endproperty
  a_sample: assert property (p_sample) else $error("pin snapshot missing");
  property p_prog;
    @(posedge tck) disable iff (!rst_n)
      isp_mode_reg && state_reg == ST_UPD_DR && ir_reg == `BST_OP_ISP_PROGRAM |=>
      nv_mem[$past(addr_reg)] == $past(data_shift_reg);
  endproperty
  a_prog: assert property (p_prog) else $error("program word not stored");
  property p_isp_hiz;
    @(posedge ref_clk) disable iff (!rst_n) isp_reg |=> pad_oe == '0;
  endproperty
  a_isp_hiz: assert property (p_isp_hiz) else $error("pins driven during programming");
  property p_extest;
    @(posedge ref_clk) disable iff (!rst_n) ext_reg && !isp_reg |=>
      pad_out == $past(sh_out_reg) && pad_oe == $past(sh_oe_reg);
  endproperty
  a_extest: assert property (p_extest) else $error("pattern not on pins");
  property p_user_tdo;
    @(posedge ref_clk) disable iff (!rst_n) !en_r_reg && $past(rst_n) |->
      {tdo_pad.tdo, tdo_pad.oe} == $past({user_tdo_out, user_tdo_oe});
  endproperty
  a_user_tdo: assert property (p_user_tdo) else $error("test pin not released");

  c_idcode: cover property (@(posedge tck) state_reg == ST_SH_DR && dr_sel == SEL_ID);
  c_prog: cover property (@(posedge tck) isp_mode_reg && state_reg == ST_UPD_DR);
  c_extest: cover property (@(posedge ref_clk) ext_reg && tgl_reg != tgl_old_reg);
  c_sig: cover property (@(posedge tck) state_reg == ST_SH_DR && dr_sel == SEL_SIG);

endmodule : bst_tap
`default_nettype wire

/* rtl/bst_defines.svh */
`ifndef BST_DEFINES_SVH
`define BST_DEFINES_SVH
`define BST_IR_LEN 10
`define BST_IR_CAPTURE 10'h001
`define BST_OP_EXTEST 10'h000
`define BST_OP_SAMPLE 10'h055
`define BST_OP_IDCODE 10'h059
`define BST_OP_USERSIG 10'h079
`define BST_OP_BYPASS 10'h3ff
`define BST_OP_ISP_ENABLE 10'h2cc
`define BST_OP_ISP_DISABLE 10'h201
`define BST_OP_ISP_ADDR 10'h203
`define BST_OP_ISP_PROGRAM 10'h2f4
`define BST_OP_ISP_READ 10'h205
`define BST_OP_ISP_ERASE 10'h2f2
`define BST_ID_LEN 32
`define BST_ID_LSB 1'b1
`define BST_SIG_LEN 16
`define BST_NV_AW 8
`define BST_NV_DEPTH 256
`define BST_SIG_ADDR 8'hff
`define BST_NV_ERASED 16'hffff
`define BST_ADDR_RST 8'h00
`define BST_BSR_LEN_0 504
`define BST_BSR_LEN_1 552
`define BST_BSR_LEN_2 600
`define BST_BSR_LEN_3 648
`define BST_CELLS_PER_PIN 3
`define BST_CELL_IN 0
`define BST_CELL_OUT 1
`define BST_CELL_OE 2
`endif

/* rtl/bst_pkg.sv */
package bst_pkg;
  typedef enum logic [3:0] {
    ST_TLR, ST_RTI, ST_SEL_DR, ST_CAP_DR, ST_SH_DR, ST_EX1_DR, ST_PAU_DR, ST_EX2_DR,
    ST_UPD_DR, ST_SEL_IR, ST_CAP_IR, ST_SH_IR, ST_EX1_IR, ST_PAU_IR, ST_EX2_IR, ST_UPD_IR
  } bst_tap_state_type;
  typedef enum logic [2:0] {
    SEL_BYP, SEL_BSR, SEL_ID, SEL_SIG, SEL_ADDR, SEL_DATA
  } bst_dr_sel_type;
  typedef struct packed {
    logic tms;
    logic tdi;
  } bst_jtag_in_type;
  typedef struct packed {
    logic tdo;
    logic oe;
  } bst_tdo_type;
endpackage : bst_pkg

/* test/bst_host.sv */
`timescale 1ns/1ps
`default_nettype none
module bst_host
  import bst_pkg::*;
(
  output logic tck,
  output bst_jtag_in_type jtag_in,
  input wire bst_tdo_type tdo_pad,
  output logic [647:0] rx_data,
  output logic rx_stb
);
  // tck only runs inside step calls and parks low between them
  initial
  begin
    tck = 1'b0;
    jtag_in = '0;
    rx_data = '0;
    rx_stb = 1'b0;
  end

  // inputs move just after falling tck; tdo is read at rising tck
  task automatic step(input logic ms, input logic di, output logic dout);
    jtag_in <= '{tms: ms, tdi: di};
    #6;
    tck = 1'b1;
    dout = tdo_pad.tdo;
    #6;
    tck = 1'b0;
  endtask : step

  // don't-care data toggles so a stale bit cannot pass for a real one
  task automatic idle(input logic ms);
    logic b;
    step(ms, ~jtag_in.tdi, b);
  endtask : idle

  task automatic tap_reset();
    repeat (6) idle(1'b1);
    idle(1'b0);
  endtask : tap_reset

  // starts and ends in run-test/idle
  task automatic scan(input logic is_ir, input int len, input logic [647:0] din);
    logic b;
    logic [647:0] dout;
    dout = '0;
    idle(1'b1);
    if (is_ir)
      idle(1'b1);
    idle(1'b0);
    idle(1'b0);
    for (int i = 0; i < len; i++)
    begin
      step(i == len - 1, din[i], b);
      dout[i] = b;
    end
    idle(1'b1);
    idle(1'b0);
    rx_data = dout;
    rx_stb = 1'b1;
    #1;
    rx_stb = 1'b0;
  endtask : scan
endmodule : bst_host
`default_nettype wire

/* test/bst_tap_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
`include "bst_defines.svh"
module bst_tap_tb_top
  import bst_pkg::*;
;
  localparam int NPIN = 168;
  localparam int BSR = 504;
  // identity fields are arbitrary
  localparam logic [31:0] ID_WORD = {4'h3, 16'h7e11, 11'h0c9, 1'b1};
  typedef struct {logic chk; logic [647:0] val;} bst_exp_type;
  logic ref_clk, rst_n, tap_en, user_tdo_out, user_tdo_oe, isp_active, tck, rx_stb;
  logic [NPIN-1:0] pad_in, core_out, core_oe, pad_out, pad_oe;
  logic [647:0] rx_data, pat;
  logic [15:0] sig;
  bst_jtag_in_type jtag_in;
  bst_tdo_type tdo_pad;
  bst_exp_type exp_q[$];
  bst_exp_type cur;
  int err_total, cmp_count;
  int unsigned seed;

  bst_tap #(.VARIANT(0), .HAS_IDCODE(1'b1), .HAS_SIG(1'b1), .ID_VERSION(ID_WORD[31:28]),
    .ID_PART(ID_WORD[27:12]), .ID_MFR(ID_WORD[11:1])) dut_u (.ref_clk(ref_clk),
    .rst_n(rst_n), .tck(tck), .jtag_in(jtag_in), .tdo_pad(tdo_pad), .tap_en(tap_en),
    .user_tdo_out(user_tdo_out), .user_tdo_oe(user_tdo_oe), .pad_in(pad_in),
    .core_out(core_out), .core_oe(core_oe), .pad_out(pad_out), .pad_oe(pad_oe),
    .isp_active(isp_active));

  bst_host host_u (.tck(tck), .jtag_in(jtag_in), .tdo_pad(tdo_pad), .rx_data(rx_data),
    .rx_stb(rx_stb));

  initial ref_clk = 1'b0;
  always #25 ref_clk = ~ref_clk;

  task automatic fail(input string m);
    err_total++;
    $display("FAIL %0t %s", $time, m);
  endtask : fail

  task automatic cmp_scan(input logic [647:0] got, input logic [647:0] exp);
    cmp_count++;
    if (got !== exp)
      fail("scan data");
  endtask : cmp_scan

  task automatic cmp_pin(input logic [647:0] got, input logic [647:0] exp);
    cmp_count++;
    if (got !== exp)
      fail("pin level");
  endtask : cmp_pin

  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : end_sim

  task automatic test_done(input string n);
    $display("test %s done", n);
  endtask : test_done

  task automatic wait_ref(input int n);
    repeat (n) @(posedge ref_clk);
    // look at pins away from the edge that launches them
    @(negedge ref_clk);
  endtask : wait_ref

  task automatic dr(input int n, input logic [647:0] din, input logic chk,
    input logic [647:0] ev);
    exp_q.push_back('{chk, ev});
    host_u.scan(1'b0, n, din);
  endtask : dr

  task automatic ir(input logic [9:0] op);
    exp_q.push_back('{1'b1, 648'(`BST_IR_CAPTURE)});
    host_u.scan(1'b1, `BST_IR_LEN, 648'(op));
  endtask : ir

  function automatic logic [647:0] rnd();
    logic [647:0] v;
    for (int k = 0; k < 648; k++)
      v[k] = 1'($urandom);
    return v;
  endfunction : rnd

  function automatic logic [647:0] cells(input logic [NPIN-1:0] i, o, e);
    logic [647:0] v;
    v = '0;
    for (int p = 0; p < NPIN; p++)
    begin
      v[3 * p + `BST_CELL_IN] = i[p];
      v[3 * p + `BST_CELL_OUT] = o[p];
      v[3 * p + `BST_CELL_OE] = e[p];
    end
    return v;
  endfunction : cells

  function automatic logic [NPIN-1:0] pick(input logic [647:0] v, input int off);
    logic [NPIN-1:0] r;
    for (int p = 0; p < NPIN; p++)
      r[p] = v[3 * p + off];
    return r;
  endfunction : pick

  // idle tck edges let the pin synchronisers settle before capture
  task automatic set_pins();
    @(posedge ref_clk);
    pad_in <= NPIN'(rnd());
    core_out <= NPIN'(rnd());
    core_oe <= NPIN'(rnd());
    wait_ref(4);
    repeat (3) host_u.idle(1'b0);
  endtask : set_pins

  task automatic nv_at(input logic [7:0] a);
    ir(`BST_OP_ISP_ADDR);
    dr(8, 648'(a), 1'b0, '0);
  endtask : nv_at

  always @(posedge rx_stb)
  begin
    if (exp_q.size() == 0)
      fail("unexpected scan");
    else
    begin
      cur = exp_q.pop_front();
      if (cur.chk)
        cmp_scan(rx_data, cur.val);
    end
  end

  initial
  begin
    #500000;
    fail("watchdog");
    end_sim();
  end

  initial
  begin
    seed = $urandom(32'ha223);
    err_total = 0;
    cmp_count = 0;
    rst_n = 1'b0;
    tap_en = 1'b1;
    user_tdo_out = 1'b0;
    user_tdo_oe = 1'b0;
    pad_in = '0;
    core_out = '0;
    core_oe = '0;
    fork
      host_u.tap_reset();
      repeat (3) @(posedge ref_clk);
    join
    rst_n <= 1'b1;
    wait_ref(2);
    host_u.tap_reset();
    dr(32, '0, 1'b1, 648'(ID_WORD));
    ir(`BST_OP_IDCODE);
    dr(32, rnd(), 1'b1, 648'(ID_WORD));
    test_done("idcode");
    ir(`BST_OP_BYPASS);
    sig = 16'(rnd());
    dr(17, 648'(sig), 1'b1, 648'({sig, 1'b0}));
    test_done("bypass");
    set_pins();
    cmp_pin(648'(pad_out), 648'(core_out));
    ir(`BST_OP_SAMPLE);
    pat = rnd();
    dr(BSR, pat, 1'b1, cells(pad_in, core_out, core_oe));
    wait_ref(8);
    cmp_pin(648'(pad_out), 648'(core_out));
    cmp_pin(648'(pad_oe), 648'(core_oe));
    ir(`BST_OP_EXTEST);
    wait_ref(8);
    cmp_pin(648'(pad_out), 648'(pick(pat, `BST_CELL_OUT)));
    cmp_pin(648'(pad_oe), 648'(pick(pat, `BST_CELL_OE)));
    set_pins();
    pat = rnd();
    dr(BSR, pat, 1'b1, cells(pad_in, core_out, core_oe));
    wait_ref(8);
    cmp_pin(648'(pad_out), 648'(pick(pat, `BST_CELL_OUT)));
    cmp_pin(648'(pad_oe), 648'(pick(pat, `BST_CELL_OE)));
    ir(`BST_OP_BYPASS);
    wait_ref(8);
    cmp_pin(648'(pad_out), 648'(core_out));
    test_done("boundary");
    ir(`BST_OP_ISP_READ);
    dr(16, '0, 1'b1, '0);
    ir(`BST_OP_ISP_ENABLE);
    wait_ref(6);
    cmp_pin(648'(isp_active), 648'(1'b1));
    cmp_pin(648'(pad_oe), '0);
    ir(`BST_OP_ISP_ERASE);
    nv_at(`BST_SIG_ADDR);
    sig = 16'(rnd());
    ir(`BST_OP_ISP_PROGRAM);
    dr(16, 648'(sig), 1'b0, '0);
    nv_at(8'h10);
    ir(`BST_OP_ISP_READ);
    dr(16, '0, 1'b1, 648'(`BST_NV_ERASED));
    nv_at(`BST_SIG_ADDR);
    ir(`BST_OP_ISP_READ);
    dr(16, '0, 1'b1, 648'(sig));
    ir(`BST_OP_ISP_DISABLE);
    wait_ref(6);
    cmp_pin(648'(isp_active), '0);
    ir(`BST_OP_USERSIG);
    dr(16, rnd(), 1'b1, 648'(sig));
    test_done("programming");
    @(posedge ref_clk);
    tap_en <= 1'b0;
    for (int k = 0; k < 4; k++)
    begin
      @(posedge ref_clk);
      user_tdo_out <= 1'($urandom);
      user_tdo_oe <= 1'($urandom);
      wait_ref(6);
      cmp_pin(648'(tdo_pad), 648'({user_tdo_out, user_tdo_oe}));
    end
    // test clock runs while disabled, so the controller must park in reset
    repeat (4) host_u.idle(1'b0);
    @(posedge ref_clk);
    tap_en <= 1'b1;
    wait_ref(2);
    repeat (3) host_u.idle(1'b0);
    dr(32, '0, 1'b1, 648'(ID_WORD));
    ir(`BST_OP_BYPASS);
    dr(1, '1, 1'b1, '0);
    test_done("port disable");
    if (exp_q.size() != 0)
      fail("scans missing");
    end_sim();
  end
endmodule : bst_tap_tb_top
`default_nettype wire
